// >>> bench/cjr_regs_tb.sv
// self-checking bench for the capture / jpeg configuration register bank
// drives the axi4-lite slave and the side inputs directly; no far-side model
`timescale 1ns/1ps
`default_nettype none
module cjr_regs_tb
	import cjr_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [9:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, dbuf = 0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic [1:0] capf = '0;
	logic [4:0] lvl_y = '0;
	logic [3:0] lvl_u = '0, lvl_v = '0, lvl_c = '0;
	logic [15:0] qdata = 16'h5a3c;
	logic awready, wready, bvalid, arready, rvalid, qtable_rd, restart_en, upscale_en;
	logic clk_en, run_en, test_en, test_bit;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [5:0] qaddr;
	logic [20:0] vb1, bs0, bs1;
	logic [10:0] ystride, wlim, hlim;
	logic [9:0] cstride;
	logic [3:0] req, rel;
	logic [15:0] rint;
	logic [7:0] ratio;
	int err_total = 0, tests_run = 0, qrd_cnt = 0, c0;
	logic [15:0] expv [16];
	// writable bits per register, index 0x2a first
	logic [15:0] msk [16] = '{16'hffff, 16'h001f, 16'h07ff, 16'h03ff, 16'h1f1f, 16'hffff,
		16'h07ff, 16'h07ff, 16'hffff, 16'h001f, 16'hffff, 16'h001f, 16'hffff, 16'h0f0f,
		16'h803f, 16'h011e};

	cjr_regs #(.ADDR_W(10)) dut (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cap_format(capf), .dbuf_en(dbuf), .luma_fifo_level(lvl_y),
		.u_fifo_level(lvl_u), .v_fifo_level(lvl_v), .coder_fifo_level(lvl_c),
		.qtable_rdata(qdata), .qtable_rd(qtable_rd), .qtable_addr(qaddr),
		.v_buf1_start(vb1), .luma_stride(ystride), .chroma_stride(cstride),
		.fifo_dram_req(req), .fifo_release(rel), .image_width_limit(wlim),
		.image_height_limit(hlim), .bitstream_buf0_start(bs0), .bitstream_buf1_start(bs1),
		.restart_interval(rint), .restart_en(restart_en), .upscale_en(upscale_en),
		.upscale_ratio(ratio), .encoder_clock_enable(clk_en), .encoder_run_enable(run_en),
		.encoder_test_enable(test_en), .encoder_test_bit(test_bit));

	initial begin
		forever #10 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (qtable_rd === 1'b1) qrd_cnt++;
	end

	task report_and_stop;
		$display("err_total=%0d tests_run=%0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask : wait_n

	// address and data offered together, each dropped once its ready is seen
	task axw(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] st);
		@(posedge mclk);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		wstrb <= st;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		// no cycle count assumed; a hang is ended by the watchdog
		do begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 0;
	endtask : axw

	task axr(input logic [7:0] idx);
		@(posedge mclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 0;
	endtask : axr

	task rchk(input logic [7:0] idx, input logic [15:0] e, input logic [1:0] er);
		axr(idx);
		chk(rd, {16'h0000, e});
		chk({30'h0, resp}, {30'h0, er});
	endtask : rchk

	task t_reset;
		for (int i = 0; i < 16; i++) begin
			rchk(8'(CJR_IDX_FIRST + i), CJR_RESET[i], CJR_RESP_OKAY);
		end
		chk(ratio, 8'h40);
		chk({restart_en, upscale_en, run_en, test_bit}, 4'h0);
	endtask : t_reset

	task lv4(input int y, input int u, input int v, input int c, input logic [3:0] eq,
		input logic [3:0] el);
		lvl_y <= 5'(y);
		lvl_u <= 4'(u);
		lvl_v <= 4'(v);
		lvl_c <= 4'(c);
		wait_n(2);
		chk(req, eq);
		chk(rel, el);
	endtask : lv4

	task t_fifo;
		capf <= 2'b10;
		lv4(8, 8, 8, 8, 4'hf, 4'h0);
		lv4(7, 7, 7, 7, 4'h0, 4'h0);
		lv4(4, 4, 4, 4, 4'h0, 4'hf);
		axw(CJR_IDX_LUMA_THR, 16'h1005, 4'hf);
		axw(CJR_IDX_CHROMA_THR, 16'h9261, 4'hf);
		axw(CJR_IDX_CODER_THR, 16'h0b03, 4'hf);
		lv4(16, 9, 6, 11, 4'hf, 4'h0);
		lv4(15, 8, 5, 10, 4'h0, 4'h0);
		lv4(5, 2, 1, 3, 4'h0, 4'hf);
		lv4(6, 3, 2, 4, 4'h0, 4'h0);
		capf <= 2'b00;
		lv4(5, 2, 1, 3, 4'h0, 4'h9);
	endtask : t_fifo

	task t_unmapped;
		axw(8'h29, 16'hffff, 4'hf);
		chk(resp, CJR_RESP_SLVERR);
		axw(8'h3a, 16'hffff, 4'hf);
		chk(resp, CJR_RESP_SLVERR);
		rchk(8'h29, 16'h0000, CJR_RESP_SLVERR);
		rchk(8'h3a, 16'h0000, CJR_RESP_SLVERR);
		rchk(CJR_IDX_V1_LOW, 16'h0000, CJR_RESP_OKAY);
	endtask : t_unmapped

	task t_pattern;
		logic [15:0] p;
		for (int i = 0; i < 16; i++) begin
			p = 16'(16'h9e37 * (i + 3));
			axw(8'(CJR_IDX_FIRST + i), p, 4'hf);
			chk(resp, CJR_RESP_OKAY);
			expv[i] = p & msk[i];
		end
		for (int i = 0; i < 16; i++) begin
			rchk(8'(CJR_IDX_FIRST + i), expv[i], CJR_RESP_OKAY);
		end
		dbuf <= 1;
		for (int f = 0; f < 4; f++) begin
			capf <= 2'(f);
			wait_n(2);
			chk(vb1, f >= 2 ? {expv[1][4:0], expv[0]} : 21'h0);
			chk(cstride, f >= 2 ? expv[3][9:0] : 10'h0);
			chk(ystride, expv[2][10:0]);
		end
		dbuf <= 0;
		wait_n(2);
		chk(vb1, 21'h0);
		chk({wlim, hlim}, {expv[6][10:0], expv[7][10:0]});
		chk(bs0, {expv[9][4:0], expv[8]});
		chk(bs1, {expv[11][4:0], expv[10]});
		chk(rint, expv[12]);
		axw(CJR_IDX_RESTART, 16'h0000, 4'hf);
		wait_n(2);
		chk(restart_en, 1'b0);
		axw(CJR_IDX_RESTART, 16'hffff, 4'b0001);
		rchk(CJR_IDX_RESTART, 16'h00ff, CJR_RESP_OKAY);
		chk(restart_en, 1'b1);
	endtask : t_pattern

	task ups(input logic [15:0] d, input logic een, input logic [7:0] er);
		axw(CJR_IDX_UPSCALE, d, 4'hf);
		wait_n(2);
		chk(upscale_en, een);
		chk(ratio, er);
	endtask : ups

	task enc(input logic [15:0] d, input logic [3:0] e);
		axw(CJR_IDX_ENC_CTRL, d, 4'hf);
		wait_n(2);
		chk({clk_en, run_en, test_en, test_bit}, e);
	endtask : enc

	task t_ctrl;
		ups(16'h8000, 1'b1, 8'h80);
		ups(16'h803f, 1'b1, 8'h7f);
		ups(16'h8001, 1'b1, 8'h41);
		ups(16'h0011, 1'b0, 8'h40);
		enc(16'h0002, 4'b0000);
		enc(16'h0012, 4'b1100);
		enc(16'h0010, 4'b1000);
		enc(16'h000c, 4'b0011);
		enc(16'h0008, 4'b0000);
		enc(16'h0004, 4'b0010);
	endtask : t_ctrl

	task t_qtab;
		axw(CJR_IDX_ENC_CTRL, 16'h0010, 4'hf);
		c0 = qrd_cnt;
		rchk(8'h45, 16'h0000, CJR_RESP_SLVERR);
		chk(qrd_cnt - c0, 0);
		axw(CJR_IDX_ENC_CTRL, 16'h0110, 4'hf);
		c0 = qrd_cnt;
		rchk(8'h6b, 16'h5a3c, CJR_RESP_OKAY);
		chk(qrd_cnt - c0, 1);
		chk(qaddr, 6'h2b);
		axw(8'h50, 16'h1234, 4'hf);
		chk(resp, CJR_RESP_SLVERR);
	endtask : t_qtab

	// second reset in mid-run must bring the defaults back
	task t_rerst;
		@(posedge mclk);
		srst <= 1;
		wait_n(2);
		srst <= 0;
		rchk(CJR_IDX_ENC_CTRL, 16'h0000, CJR_RESP_OKAY);
		rchk(CJR_IDX_LUMA_THR, 16'h0804, CJR_RESP_OKAY);
		chk(run_en, 1'b0);
	endtask : t_rerst

	initial begin
		repeat (4) @(posedge mclk);
		srst <= 0;
		t_reset();
		t_fifo();
		t_unmapped();
		t_pattern();
		t_ctrl();
		t_qtab();
		t_rerst();
		report_and_stop();
	end

	// the sequence needs a few hundred cycles; this allows ten thousand
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
endmodule : cjr_regs_tb
`default_nettype wire

// >>> hdl/cjr_pkg.sv
// package for the capture / jpeg configuration register bank
// assumes a 32-bit axi4-lite master; register index = byte address / 4
package cjr_pkg;
	localparam int CJR_NREG = 16;
	localparam logic [7:0] CJR_IDX_FIRST = 8'h2a;
	localparam logic [7:0] CJR_IDX_LAST = 8'h39;
	localparam logic [7:0] CJR_IDX_V1_LOW = 8'h2a;
	localparam logic [7:0] CJR_IDX_V1_HIGH = 8'h2b;
	localparam logic [7:0] CJR_IDX_LUMA_STRIDE = 8'h2c;
	localparam logic [7:0] CJR_IDX_CHROMA_STRIDE = 8'h2d;
	localparam logic [7:0] CJR_IDX_LUMA_THR = 8'h2e;
	localparam logic [7:0] CJR_IDX_CHROMA_THR = 8'h2f;
	localparam logic [7:0] CJR_IDX_MAX_WIDTH = 8'h30;
	localparam logic [7:0] CJR_IDX_MAX_HEIGHT = 8'h31;
	localparam logic [7:0] CJR_IDX_BS0_LOW = 8'h32;
	localparam logic [7:0] CJR_IDX_BS0_HIGH = 8'h33;
	localparam logic [7:0] CJR_IDX_BS1_LOW = 8'h34;
	localparam logic [7:0] CJR_IDX_BS1_HIGH = 8'h35;
	localparam logic [7:0] CJR_IDX_RESTART = 8'h36;
	localparam logic [7:0] CJR_IDX_CODER_THR = 8'h37;
	localparam logic [7:0] CJR_IDX_UPSCALE = 8'h38;
	localparam logic [7:0] CJR_IDX_ENC_CTRL = 8'h39;
	localparam logic [7:0] CJR_IDX_QTAB_FIRST = 8'h40;
	localparam logic [7:0] CJR_IDX_QTAB_LAST = 8'h7f;
	// writable bits per register, entry 0 is index 0x2a
	localparam logic [0:CJR_NREG-1][15:0] CJR_MASK = {
		16'hffff, 16'h001f, 16'h07ff, 16'h03ff, 16'h1f1f, 16'hffff, 16'h07ff, 16'h07ff,
		16'hffff, 16'h001f, 16'hffff, 16'h001f, 16'hffff, 16'h0f0f, 16'h803f, 16'h011e};
	localparam logic [0:CJR_NREG-1][15:0] CJR_RESET = {
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0804, 16'h8484, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0804, 16'h0000, 16'h0000};
	localparam int CJR_UPS_EN_BIT = 15;
	localparam int CJR_QRD_BIT = 8;
	localparam int CJR_CLKEN_BIT = 4;
	localparam int CJR_TEST_BIT = 3;
	localparam int CJR_TEN_BIT = 2;
	localparam int CJR_RUN_BIT = 1;
	localparam logic [7:0] CJR_RATIO_ONE = 8'h40;
	localparam logic [7:0] CJR_RATIO_MAX = 8'h80;
	localparam logic [1:0] CJR_RESP_OKAY = 2'b00;
	localparam logic [1:0] CJR_RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {CJR_WS_IDLE = 2'b01, CJR_WS_RESP = 2'b10} cjr_wstate_t;
	typedef enum logic [2:0] {
		CJR_RS_IDLE = 3'b001, CJR_RS_DATA = 3'b010, CJR_RS_RESP = 3'b100} cjr_rstate_t;
endpackage : cjr_pkg

// >>> hdl/cjr_regs.sv
// capture tail and jpeg encoder configuration registers behind an axi4-lite slave
// assumes inputs synchronous to mclk; capture format and double buffering come from outside
//
// What this block does
// - second v buffer start is 21 bits: low 16 in one register, top 5 next
// - second v buffer start used only for planar capture with double buffering
// - 11-bit luma stride, shared by both capture buffers
// - 10-bit chroma stride, shared by both buffers, unused when packed
// - luma fifo at 5-bit high threshold requests dram; default 8
// - luma fifo drained to 5-bit low threshold may release dram; default 4
// - u fifo 4-bit high/low thresholds, defaults 8 and 4, unused when packed
// - v fifo 4-bit high/low thresholds, defaults 8 and 4, unused when packed
// - maximum image width and height, 11 bits each, upper bits reserved
// - two bitstream buffer starts, 21 bits each, split low 16 and high 5
// - 16-bit restart interval in mcus; zero disables restarts; resets to zero
// - entropy coder fifo at 4-bit high threshold requests dram; default 8
// - entropy coder fifo drained to 4-bit low threshold may release; default 4
// - vertical up-scaling only while its enable bit is set; resets off
// - up-scale ratio is one plus factor/64; factor zero gives ratio two
// - quantization tables readable only while table read enable is set
// - encoder runs only while its run enable bit is set; resets off
// - test enable puts encoder into test mode; test bit matters only there
// - 2-bit capture format: 4:2:2/4:2:0 packed, then 4:2:2/4:2:0 planar
// - double buffering enable selects whether buffer set 1 is used
`timescale 1ns/1ps
`default_nettype none
module cjr_regs
	import cjr_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] cap_format,
	input wire logic dbuf_en,
	input wire logic [4:0] luma_fifo_level,
	input wire logic [3:0] u_fifo_level,
	input wire logic [3:0] v_fifo_level,
	input wire logic [3:0] coder_fifo_level,
	input wire logic [15:0] qtable_rdata,
	output logic qtable_rd,
	output logic [5:0] qtable_addr,
	output logic [20:0] v_buf1_start,
	output logic [10:0] luma_stride,
	output logic [9:0] chroma_stride,
	output logic [3:0] fifo_dram_req,
	output logic [3:0] fifo_release,
	output logic [10:0] image_width_limit,
	output logic [10:0] image_height_limit,
	output logic [20:0] bitstream_buf0_start,
	output logic [20:0] bitstream_buf1_start,
	output logic [15:0] restart_interval,
	output logic restart_en,
	output logic upscale_en,
	output logic [7:0] upscale_ratio,
	output logic encoder_clock_enable,
	output logic encoder_run_enable,
	output logic encoder_test_enable,
	output logic encoder_test_bit
);
	localparam int NF = 4;

	// ---------------- register storage ----------------
	logic [15:0] reg_q [CJR_NREG];
	logic [15:0] reg_d [CJR_NREG];

	// ---------------- write channel ----------------
	cjr_wstate_t ws_q, ws_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic [7:0] widx_q, widx_d;
	logic [15:0] wdata_q, wdata_d;
	logic [1:0] wstrb_q, wstrb_d;
	logic do_write, wr_hit;
	logic [3:0] wsel;

	always_comb begin
		do_write = (ws_q == CJR_WS_IDLE) && aw_got_q && w_got_q;
		wr_hit = (widx_q >= CJR_IDX_FIRST) && (widx_q <= CJR_IDX_LAST);
		wsel = 4'(widx_q - CJR_IDX_FIRST);
		ws_d = ws_q;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		widx_d = widx_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		case (ws_q)
			CJR_WS_IDLE: begin
				if (s_axi_awvalid && awready_q) begin
					aw_got_d = 1'b1;
					widx_d = s_axi_awaddr[9:2];
				end
				if (s_axi_wvalid && wready_q) begin
					w_got_d = 1'b1;
					wdata_d = s_axi_wdata[15:0];
					wstrb_d = s_axi_wstrb[1:0];
				end
				if (do_write) begin
					ws_d = CJR_WS_RESP;
					bvalid_d = 1'b1;
					bresp_d = wr_hit ? CJR_RESP_OKAY : CJR_RESP_SLVERR;
				end
			end
			CJR_WS_RESP: begin
				if (s_axi_bready) begin
					ws_d = CJR_WS_IDLE;
					bvalid_d = 1'b0;
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
				end
			end
			default: begin
				ws_d = CJR_WS_IDLE;
				bvalid_d = 1'b0;
				aw_got_d = 1'b0;
				w_got_d = 1'b0;
			end
		endcase
		awready_d = (ws_d == CJR_WS_IDLE) && !aw_got_d;
		wready_d = (ws_d == CJR_WS_IDLE) && !w_got_d;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ws_q <= CJR_WS_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= CJR_RESP_OKAY;
			widx_q <= 8'h00;
			wdata_q <= 16'h0000;
			wstrb_q <= 2'b00;
		end else begin
			ws_q <= ws_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			widx_q <= widx_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
		end
	end

	// byte lanes above bit 15 have nothing behind them
	genvar gi;
	generate
		for (gi = 0; gi < CJR_NREG; gi++) begin : g_reg
			always_comb begin
				reg_d[gi] = reg_q[gi];
				if (do_write && wr_hit && (wsel == 4'(gi))) begin
					reg_d[gi] = {wstrb_q[1] ? wdata_q[15:8] : reg_q[gi][15:8],
						wstrb_q[0] ? wdata_q[7:0] : reg_q[gi][7:0]} & CJR_MASK[gi];
				end
			end
			always_ff @(posedge mclk) begin
				if (srst) begin
					reg_q[gi] <= CJR_RESET[gi];
				end else begin
					reg_q[gi] <= reg_d[gi];
				end
			end
		end
	endgenerate

	// ---------------- read channel ----------------
	cjr_rstate_t rs_q, rs_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] ridx_q, ridx_d;
	logic qrd_q, qrd_d;
	logic rd_reg, rd_qtab;
	logic [3:0] rsel;

	always_comb begin
		rd_reg = (ridx_q >= CJR_IDX_FIRST) && (ridx_q <= CJR_IDX_LAST);
		rd_qtab = (ridx_q >= CJR_IDX_QTAB_FIRST) && (ridx_q <= CJR_IDX_QTAB_LAST);
		rsel = 4'(ridx_q - CJR_IDX_FIRST);
		rs_d = rs_q;
		ridx_d = ridx_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		qrd_d = 1'b0;
		case (rs_q)
			CJR_RS_IDLE: begin
				if (s_axi_arvalid && arready_q) begin
					rs_d = CJR_RS_DATA;
					ridx_d = s_axi_araddr[9:2];
					// table read strobe only when software has opened the tables
					qrd_d = (s_axi_araddr[9:2] >= CJR_IDX_QTAB_FIRST) &&
						(s_axi_araddr[9:2] <= CJR_IDX_QTAB_LAST) &&
						reg_q[15][CJR_QRD_BIT];
				end
			end
			CJR_RS_DATA: begin
				rs_d = CJR_RS_RESP;
				rvalid_d = 1'b1;
				if (rd_reg) begin
					rdata_d = {16'h0000, reg_q[rsel]};
					rresp_d = CJR_RESP_OKAY;
				end else if (rd_qtab && reg_q[15][CJR_QRD_BIT]) begin
					rdata_d = {16'h0000, qtable_rdata};
					rresp_d = CJR_RESP_OKAY;
				end else begin
					rdata_d = 32'h0000_0000;
					rresp_d = CJR_RESP_SLVERR;
				end
			end
			CJR_RS_RESP: begin
				if (s_axi_rready) begin
					rs_d = CJR_RS_IDLE;
					rvalid_d = 1'b0;
				end
			end
			default: begin
				rs_d = CJR_RS_IDLE;
				rvalid_d = 1'b0;
			end
		endcase
		arready_d = (rs_d == CJR_RS_IDLE);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rs_q <= CJR_RS_IDLE;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= CJR_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			ridx_q <= 8'h00;
			qrd_q <= 1'b0;
		end else begin
			rs_q <= rs_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			ridx_q <= ridx_d;
			qrd_q <= qrd_d;
		end
	end

	// ---------------- decoded configuration outputs ----------------
	logic planar, dbuf_planar;
	logic [4:0] lvl [NF];
	logic [4:0] hi [NF];
	logic [4:0] lo [NF];
	logic [NF-1:0] used, req_d, req_q, rel_d, rel_q;
	logic [20:0] v1_d, v1_q;
	logic [7:0] ratio_d, ratio_q;
	logic restart_en_q, run_q, tbit_q;
	logic [9:0] chroma_q;

	always_comb begin
		planar = cap_format[1];
		dbuf_planar = planar && dbuf_en;
		v1_d = dbuf_planar ? {reg_q[1][4:0], reg_q[0]} : 21'h000000;
		lvl[0] = luma_fifo_level;
		lvl[1] = {1'b0, u_fifo_level};
		lvl[2] = {1'b0, v_fifo_level};
		lvl[3] = {1'b0, coder_fifo_level};
		hi[0] = reg_q[4][12:8];
		lo[0] = reg_q[4][4:0];
		hi[1] = {1'b0, reg_q[5][15:12]};
		lo[1] = {1'b0, reg_q[5][11:8]};
		hi[2] = {1'b0, reg_q[5][7:4]};
		lo[2] = {1'b0, reg_q[5][3:0]};
		hi[3] = {1'b0, reg_q[13][11:8]};
		lo[3] = {1'b0, reg_q[13][3:0]};
		used = {1'b1, planar, planar, 1'b1};
		// zero factor means the largest step, not unity
		ratio_d = (reg_q[14][5:0] == 6'h00) ? CJR_RATIO_MAX :
			(CJR_RATIO_ONE + {2'b00, reg_q[14][5:0]});
		if (!reg_q[14][CJR_UPS_EN_BIT]) begin
			ratio_d = CJR_RATIO_ONE;
		end
	end

	generate
		for (gi = 0; gi < NF; gi++) begin : g_fifo
			always_comb begin
				req_d[gi] = used[gi] && (lvl[gi] >= hi[gi]);
				rel_d[gi] = used[gi] && (lvl[gi] <= lo[gi]);
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (srst) begin
			v1_q <= 21'h000000;
			req_q <= '0;
			rel_q <= '0;
			ratio_q <= CJR_RATIO_ONE;
		end else begin
			v1_q <= v1_d;
			req_q <= req_d;
			rel_q <= rel_d;
			ratio_q <= ratio_d;
		end
	end

	// these are direct register fields, all but chroma_stride; the register itself is the output flop
	assign luma_stride = reg_q[2][10:0];
	assign chroma_stride = chroma_q;
	assign image_width_limit = reg_q[6][10:0];
	assign image_height_limit = reg_q[7][10:0];
	assign bitstream_buf0_start = {reg_q[9][4:0], reg_q[8]};
	assign bitstream_buf1_start = {reg_q[11][4:0], reg_q[10]};
	assign restart_interval = reg_q[12];
	assign upscale_en = reg_q[14][CJR_UPS_EN_BIT];
	assign encoder_clock_enable = reg_q[15][CJR_CLKEN_BIT];
	assign encoder_test_enable = reg_q[15][CJR_TEN_BIT];

	always_ff @(posedge mclk) begin
		if (srst) begin
			chroma_q <= 10'h000;
			restart_en_q <= 1'b0;
			run_q <= 1'b0;
			tbit_q <= 1'b0;
		end else begin
			// chroma stride means nothing in packed capture, so it reads zero there
			chroma_q <= planar ? reg_q[3][9:0] : 10'h000;
			restart_en_q <= (reg_q[12] != 16'h0000);
			// a run request without the encoder clock would stall the core
			run_q <= reg_q[15][CJR_RUN_BIT] && reg_q[15][CJR_CLKEN_BIT];
			tbit_q <= reg_q[15][CJR_TEN_BIT] && reg_q[15][CJR_TEST_BIT];
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign qtable_rd = qrd_q;
	assign qtable_addr = ridx_q[5:0];
	assign v_buf1_start = v1_q;
	assign fifo_dram_req = req_q;
	assign fifo_release = rel_q;
	assign restart_en = restart_en_q;
	assign upscale_ratio = ratio_q;
	assign encoder_run_enable = run_q;
	assign encoder_test_bit = tbit_q;

	// ---------------- checks ----------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	chk_v1_gated: assert property (!(cap_format[1] && dbuf_en) |=> v_buf1_start == 21'h0)
		else $error("second v buffer start visible outside planar double buffering");
	chk_v1_value: assert property ((cap_format[1] && dbuf_en) |=>
		v_buf1_start == {$past(reg_q[1][4:0]), $past(reg_q[0])})
		else $error("second v buffer start not assembled from its two halves");
	chk_luma_req: assert property ((luma_fifo_level >= reg_q[4][12:8]) |=> fifo_dram_req[0])
		else $error("luma fifo at high threshold without dram request");
	chk_luma_rel: assert property ((luma_fifo_level > reg_q[4][4:0]) |=> !fifo_release[0])
		else $error("luma fifo released above low threshold");
	chk_uv_packed: assert property (!cap_format[1] |=>
		(fifo_dram_req[2:1] == 2'b00) && (fifo_release[2:1] == 2'b00))
		else $error("u or v fifo active in packed capture");
	chk_v_req: assert property ((cap_format[1] && v_fifo_level >= reg_q[5][7:4]) |=>
		fifo_dram_req[2])
		else $error("v fifo at high threshold without request");
	chk_coder_req: assert property ((coder_fifo_level >= reg_q[13][11:8]) |=>
		fifo_dram_req[3])
		else $error("coder fifo at high threshold without request");
	chk_coder_rel: assert property ((coder_fifo_level <= reg_q[13][3:0]) |=>
		fifo_release[3])
		else $error("coder fifo at low threshold not released");
	chk_ratio_max: assert property ((upscale_en && reg_q[14][5:0] == 6'h00) |=>
		upscale_ratio == 8'h80)
		else $error("zero up-scale factor did not give ratio two");
	chk_upscale_off: assert property (!upscale_en |=> upscale_ratio == 8'h40)
		else $error("up-scaling applied while disabled");
	chk_restart_zero: assert property ((restart_interval == 16'h0) |=> !restart_en)
		else $error("restart processing on with zero interval");
	chk_qtable_gate: assert property ((rs_q == CJR_RS_DATA && rd_qtab && !reg_q[15][8]) |=>
		(s_axi_rresp == 2'b10) && (s_axi_rdata == 32'h0) && s_axi_rvalid)
		else $error("quantization table readable while locked");
	chk_run_gate: assert property (!reg_q[15][1] |=> !encoder_run_enable)
		else $error("encoder running with enable clear");
	chk_test_gate: assert property (!encoder_test_enable |=> !encoder_test_bit)
		else $error("test bit active outside test mode");
	chk_rsvd_zero: assert property (((reg_q[15] & ~CJR_MASK[15]) == 16'h0000) &&
		((reg_q[14] & ~CJR_MASK[14]) == 16'h0000) && ((reg_q[4] & ~CJR_MASK[4]) == 16'h0000))
		else $error("reserved bits hold a nonzero value");
	chk_write_resp: assert property (do_write |=> s_axi_bvalid)
		else $error("write not answered one cycle after both halves held");

	cov_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00);
	cov_qtab_read: cover property (s_axi_rvalid && qrd_q == 1'b0 && rd_qtab && s_axi_rresp == 2'b00);
	cov_ratio_max: cover property (upscale_ratio == 8'h80);
	cov_planar_req: cover property (fifo_dram_req[1] && fifo_dram_req[2]);
endmodule : cjr_regs
`default_nettype wire
